// ### design/audio_port_pkg.sv
// audio_port_pkg: register map, field layouts, modes and rate constants
// for the shared i2s / pcm audio serial port; mclk is the divider reference
package audio_port_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS  = 8'h04;
  localparam logic [7:0] SLOT_OFS = 8'h08;
  localparam logic [7:0] FMT_OFS  = 8'h0C;
  localparam logic [7:0] TX0_OFS  = 8'h10;
  localparam logic [7:0] TX1_OFS  = 8'h14;
  localparam logic [7:0] TX2_OFS  = 8'h18;
  localparam logic [7:0] RX0_OFS  = 8'h1C;
  localparam logic [7:0] RX1_OFS  = 8'h20;
  localparam logic [7:0] RX2_OFS  = 8'h24;
  localparam logic [7:0] STAT_OFS = 8'h28;

  // datapath sizes
  localparam int NUM_CH        = 3;
  localparam int SLOT_FLD_BITS = 5;
  localparam int PCM_RATE_MAX  = 4;
  localparam int LONG_SYNC_BITS = 3;

  // rates
  localparam int REF_CLK_HZ       = 100_000_000;
  localparam int I2S_FRAME_HZ     = 32_000;
  localparam int I2S_BITS_NARROW  = 32;
  localparam int I2S_BITS_WIDE    = 50;
  localparam int SLAVE_MAX_CLK_HZ = 3_072_000;

  // divider default: two ticks per bit at 32 bits x 32 kHz from mclk
  localparam logic [15:0] DIV_N_RST = 16'(2 * I2S_BITS_NARROW);
  localparam logic [15:0] DIV_M_RST = 16'(REF_CLK_HZ / I2S_FRAME_HZ);

  typedef enum logic [2:0] {
    MODE_OFF, MODE_I2S_MST, MODE_I2S_SLV, MODE_PCM_MST, MODE_PCM_SLV
  } mode_type;

  typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_PROG} fill_type;

  typedef struct packed {
    logic       longSync;
    logic [2:0] pcmRate;
    logic       i2sWide;
    mode_type   mode;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] fillVal;
    fill_type   fillMode;
    logic       lsbFirst;
    logic       rightJust;
  } fmt_type;

  typedef struct packed {
    logic       en;
    logic [3:0] num;
  } slot_type;

  typedef struct packed {
    logic [15:0] m;
    logic [15:0] n;
  } div_type;

  localparam ctrl_type CTRL_RST = ctrl_type'(8'h00);
  localparam fmt_type  FMT_RST  = fmt_type'(7'h00);
  localparam div_type  DIV_RST  = '{m: DIV_M_RST, n: DIV_N_RST};

endpackage : audio_port_pkg

// ### design/audio_serial_port.sv
// audio_serial_port: one shared serial datapath, run as i2s stereo or
// multi-slot pcm, master or slave, configured over an ahb-lite slave.
// assumes a single ahb master and pins resolved by the surrounding pad ring.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module audio_serial_port
  import audio_port_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial pins: i2s sck / pcm clock
  input  wire logic        audioSerialClkIn,
  output logic             audioSerialClkOut,
  output logic             audioSerialClkOe,
  // i2s word select / pcm sync
  input  wire logic        audioSerialFrameIn,
  output logic             audioSerialFrameOut,
  output logic             audioSerialFrameOe,
  // serial data
  output logic             audioSerialDataOut,
  output logic             audioSerialDataOe,
  input  wire logic        audio_serial_data_in_unused_guard,
  input  wire logic        audioSerialDataIn
);

  // ---------------- bus slave ----------------
  ctrl_type    ctrl_r;
  div_type     div_r;
  fmt_type     fmt_r;
  slot_type    slot_r [NUM_CH];
  logic [15:0] txData_r [NUM_CH];
  logic [15:0] rxData_r [NUM_CH];
  logic [31:0] hrdata_r;
  logic [7:0]  wrAddr_r;
  logic        wrPend_r;
  logic        addrPhase;
  logic        modeChg;
  logic [31:0] rdMux;
  logic [31:0] statWord;

  assign addrPhase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else if (hready) begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // a write to the mode field restarts the datapath cleanly
  assign modeChg = wrPend_r && (wrAddr_r == CTRL_OFS);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      div_r  <= DIV_RST;
      fmt_r  <= FMT_RST;
      for (int c = 0; c < NUM_CH; c++) begin
        slot_r[c]   <= slot_type'(5'h00);
        txData_r[c] <= 16'h0000;
      end
    end else if (wrPend_r) begin
      case (wrAddr_r)
        CTRL_OFS: ctrl_r <= ctrl_type'(hwdata[7:0]);
        DIV_OFS:  div_r <= div_type'(hwdata);
        FMT_OFS:  fmt_r <= fmt_type'(hwdata[6:0]);
        SLOT_OFS: begin
          for (int c = 0; c < NUM_CH; c++) begin
            slot_r[c] <= slot_type'(hwdata[c*SLOT_FLD_BITS +: SLOT_FLD_BITS]);
          end
        end
        TX0_OFS: txData_r[0] <= hwdata[15:0];
        TX1_OFS: txData_r[1] <= hwdata[15:0];
        TX2_OFS: txData_r[2] <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (haddr[7:0])
      CTRL_OFS: rdMux = {24'h00_0000, ctrl_r};
      DIV_OFS:  rdMux = div_r;
      FMT_OFS:  rdMux = {25'h000_0000, fmt_r};
      SLOT_OFS: rdMux = {17'h0_0000, slot_r[2], slot_r[1], slot_r[0]};
      TX0_OFS:  rdMux = {16'h0000, txData_r[0]};
      TX1_OFS:  rdMux = {16'h0000, txData_r[1]};
      TX2_OFS:  rdMux = {16'h0000, txData_r[2]};
      RX0_OFS:  rdMux = {16'h0000, rxData_r[0]};
      RX1_OFS:  rdMux = {16'h0000, rxData_r[1]};
      RX2_OFS:  rdMux = {16'h0000, rxData_r[2]};
      STAT_OFS: rdMux = statWord;
      default:  rdMux = 32'h0000_0000;
    endcase
  end

  // read data sampled in the address phase: zero wait states
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata_r <= rdMux;
    end
  end

  // ---------------- mode decode ----------------
  logic isI2s;
  logic isPcm;
  logic isMaster;
  logic active;
  logic dpRst;

  assign isI2s    = (ctrl_r.mode == MODE_I2S_MST) || (ctrl_r.mode == MODE_I2S_SLV);
  assign isPcm    = (ctrl_r.mode == MODE_PCM_MST) || (ctrl_r.mode == MODE_PCM_SLV);
  assign isMaster = (ctrl_r.mode == MODE_I2S_MST) || (ctrl_r.mode == MODE_PCM_MST);
  assign active   = isI2s || isPcm;
  assign dpRst    = rst || modeChg;

  // ---------------- bit clock source ----------------
  logic [15:0] acc_r;
  logic [16:0] accSum;
  logic        tick;
  logic        clkOut_r;

  assign accSum = {1'b0, acc_r} + {1'b0, div_r.n};
  assign tick   = isMaster && (accSum >= {1'b0, div_r.m});

  always_ff @(posedge mclk) begin
    if (dpRst || !isMaster) begin
      acc_r <= 16'h0000;
    end else if (tick) begin
      acc_r <= 16'(accSum - {1'b0, div_r.m});
    end else begin
      acc_r <= accSum[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (dpRst || !isMaster) begin
      clkOut_r <= 1'b0;
    end else if (tick) begin
      clkOut_r <= !clkOut_r;
    end
  end

  // pin synchronisers; edge detection compares the second and third stages
  logic clkS1_r, clkS2_r, clkS3_r;
  logic frmS1_r, frmS2_r;
  logic dinS1_r, dinS2_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      {clkS1_r, clkS2_r, clkS3_r} <= 3'h0;
      {frmS1_r, frmS2_r}          <= 2'h0;
      {dinS1_r, dinS2_r}          <= 2'h0;
    end else begin
      clkS1_r <= audioSerialClkIn;
      clkS2_r <= clkS1_r;
      clkS3_r <= clkS2_r;
      frmS1_r <= audioSerialFrameIn;
      frmS2_r <= frmS1_r;
      dinS1_r <= audioSerialDataIn;
      dinS2_r <= dinS1_r;
    end
  end

  // slave clock is oversampled; 3.072 MHz leaves over 30 mclk per bit
  logic riseEv, fallEv, frameLvl, din, frameOut_r;
  assign riseEv   = active && (isMaster ? (tick && !clkOut_r) : (clkS2_r && !clkS3_r));
  assign fallEv   = active && (isMaster ? (tick && clkOut_r) : (!clkS2_r && clkS3_r));
  assign frameLvl = isMaster ? frameOut_r : frmS2_r;
  assign din      = dinS2_r;

  // ---------------- i2s framing ----------------
  logic [5:0] i2sCnt_r;
  logic [5:0] i2sLast;
  logic [5:0] i2sHalf;
  logic [5:0] i2sNext;
  logic       wsRise_r;
  logic       wsFall_r;
  logic       wsChg;

  assign i2sLast = ctrl_r.i2sWide ? 6'(I2S_BITS_WIDE - 1) : 6'(I2S_BITS_NARROW - 1);
  assign i2sHalf = ctrl_r.i2sWide ? 6'(I2S_BITS_WIDE / 2) : 6'(I2S_BITS_NARROW / 2);
  assign i2sNext = (i2sCnt_r == i2sLast) ? 6'h00 : 6'(i2sCnt_r + 6'h01);
  assign wsChg   = wsRise_r != wsFall_r;

  always_ff @(posedge mclk) begin
    if (dpRst) begin
      i2sCnt_r <= 6'h00;
      wsRise_r <= 1'b0;
      wsFall_r <= 1'b0;
    end else begin
      if (isI2s && isMaster && fallEv) begin
        i2sCnt_r <= i2sNext;
      end
      if (isI2s && riseEv) begin
        wsRise_r <= frameLvl;
      end
      if (isI2s && fallEv) begin
        wsFall_r <= wsRise_r;
      end
    end
  end

  // ---------------- pcm framing ----------------
  logic [2:0] rateSel;
  logic [7:0] pcmLast;
  logic [7:0] bitCnt_r;
  logic [7:0] nextBit_r;
  logic       syncFall_r;
  logic       aligned_r;

  assign rateSel = (ctrl_r.pcmRate > 3'(PCM_RATE_MAX)) ? 3'(PCM_RATE_MAX) : ctrl_r.pcmRate;
  assign pcmLast = 8'((9'h010 << rateSel) - 9'h001);

  always_ff @(posedge mclk) begin
    if (dpRst) begin
      bitCnt_r   <= 8'h00;
      nextBit_r  <= 8'h00;
      syncFall_r <= 1'b0;
      aligned_r  <= 1'b0;
    end else if (isPcm) begin
      if (isMaster) begin
        aligned_r <= 1'b1;
      end
      if (riseEv) begin
        bitCnt_r <= nextBit_r;
      end
      if (fallEv) begin
        syncFall_r <= frameLvl;
        nextBit_r  <= (bitCnt_r == pcmLast) ? 8'h00 : 8'(bitCnt_r + 8'h01);
        if (!isMaster && !ctrl_r.longSync && frameLvl) begin
          nextBit_r <= 8'h00;
          aligned_r <= 1'b1;
        end
        if (!isMaster && ctrl_r.longSync && frameLvl && !syncFall_r) begin
          nextBit_r <= 8'h01;
          aligned_r <= 1'b1;
        end
      end
    end
  end

  // frame output: i2s word select on falls, pcm sync on rises
  always_ff @(posedge mclk) begin
    if (dpRst) begin
      frameOut_r <= 1'b0;
    end else if (isI2s && isMaster && fallEv) begin
      frameOut_r <= i2sNext >= i2sHalf;
    end else if (isPcm && isMaster && riseEv) begin
      if (ctrl_r.longSync) begin
        frameOut_r <= nextBit_r < 8'(LONG_SYNC_BITS);
      end else begin
        frameOut_r <= nextBit_r == pcmLast;
      end
    end
  end

  // slot ownership lookup
  function automatic logic [2:0] slotOwner(input logic [7:0] bitNum);
    logic [2:0] res;
    res = 3'h0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (slot_r[c].en && (slot_r[c].num == bitNum[7:4])) begin
        res = {1'b1, 2'(c)};
      end
    end
    return res;
  endfunction : slotOwner

  // sample formatting
  function automatic logic [15:0] packWord(input logic [15:0] s, input fmt_type f);
    logic [2:0]  fill;
    logic [15:0] w;
    unique case (f.fillMode)
      FILL_ZERO: fill = 3'h0;
      FILL_ONE:  fill = 3'h7;
      FILL_SIGN: fill = {3{s[12]}};
      FILL_PROG: fill = f.fillVal;
    endcase
    w = f.rightJust ? {fill, s[12:0]} : {s[12:0], fill};
    return f.lsbFirst ? {<<{w}} : w;
  endfunction : packWord

  function automatic logic [15:0] unpackWord(input logic [15:0] w, input fmt_type f);
    logic [15:0] o;
    logic [12:0] s;
    o = f.lsbFirst ? {<<{w}} : w;
    s = f.rightJust ? o[12:0] : o[15:3];
    return {{3{s[12]}}, s};
  endfunction : unpackWord

  // ---------------- shared transmit shifter ----------------
  logic [15:0] txSh_r;
  logic        dout_r;
  logic        pcmOe_r;
  logic [2:0]  txOwn;
  logic [15:0] txWord;
  logic [15:0] pcmTxWord;

  // always_comb so that slot register writes also re-evaluate the lookup
  always_comb txOwn = slotOwner(nextBit_r);
  assign txWord    = wsRise_r ? txData_r[1] : txData_r[0];
  assign pcmTxWord = packWord(txData_r[txOwn[1:0]], fmt_r);

  always_ff @(posedge mclk) begin
    if (dpRst) begin
      txSh_r  <= 16'h0000;
      dout_r  <= 1'b0;
      pcmOe_r <= 1'b0;
    end else if (isI2s && fallEv) begin
      if (wsChg) begin
        dout_r <= txWord[15];
        txSh_r <= {txWord[14:0], 1'b0};
      end else begin
        dout_r <= txSh_r[15];
        txSh_r <= {txSh_r[14:0], 1'b0};
      end
    end else if (isPcm && riseEv) begin
      if (!txOwn[2]) begin
        pcmOe_r <= 1'b0;
      end else if (nextBit_r[3:0] == 4'h0) begin
        dout_r  <= pcmTxWord[15];
        txSh_r  <= {pcmTxWord[14:0], 1'b0};
        pcmOe_r <= aligned_r;
      end else begin
        dout_r <= txSh_r[15];
        txSh_r <= {txSh_r[14:0], 1'b0};
      end
    end else if (isPcm && fallEv && (bitCnt_r[3:0] == 4'hF)) begin
      pcmOe_r <= 1'b0;
    end
  end

  // ---------------- shared receive shifter ----------------
  logic [15:0] rxSh_r;
  logic [4:0]  rxCnt_r;
  logic [1:0]  rxCh_r;
  logic [2:0]  rxOwn;
  logic [15:0] rxFull;

  always_comb rxOwn = slotOwner(bitCnt_r);
  assign rxFull = {rxSh_r[14:0], din};

  // far end launches on falls, so i2s bits are taken on rises
  always_ff @(posedge mclk) begin
    if (dpRst) begin
      rxSh_r  <= 16'h0000;
      rxCnt_r <= 5'h10;
      rxCh_r  <= 2'h0;
      for (int c = 0; c < NUM_CH; c++) begin
        rxData_r[c] <= 16'h0000;
      end
    end else if (isI2s && fallEv && wsChg) begin
      rxCnt_r <= 5'h00;
      rxCh_r  <= {1'b0, wsRise_r};
    end else if (isI2s && riseEv && (rxCnt_r < 5'h10)) begin
      rxSh_r  <= rxFull;
      rxCnt_r <= 5'(rxCnt_r + 5'h01);
      if (rxCnt_r == 5'h0F) begin
        rxData_r[rxCh_r] <= rxFull;
      end
    end else if (isPcm && fallEv && rxOwn[2] && aligned_r) begin
      rxSh_r <= rxFull;
      if (bitCnt_r[3:0] == 4'hF) begin
        rxData_r[rxOwn[1:0]] <= unpackWord(rxFull, fmt_r);
      end
    end
  end

  // ---------------- pins and status ----------------
  assign audioSerialClkOut   = clkOut_r;
  assign audioSerialClkOe    = isMaster;
  assign audioSerialFrameOut = frameOut_r;
  assign audioSerialFrameOe  = isMaster;
  assign audioSerialDataOut  = dout_r;
  assign audioSerialDataOe   = isI2s || (isPcm && pcmOe_r);
  assign statWord = {20'h0_0000, aligned_r, isMaster, active, 1'b0, bitCnt_r};

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_dir_master: assert property (isMaster |-> audioSerialClkOe && audioSerialFrameOe)
    else $error("master does not drive clock and frame");
  chk_dir_slave: assert property (active && !isMaster |-> !audioSerialClkOe && !audioSerialFrameOe)
    else $error("slave drives clock or frame");
  chk_dout_i2s: assert property (isI2s |-> audioSerialDataOe)
    else $error("i2s data output not driven");
  chk_i2s_msb: assert property (isI2s && fallEv && wsChg && !modeChg |=> dout_r == $past(txWord[15]))
    else $error("i2s msb not launched after word select change");
  chk_pcm_release: assert property (isPcm && fallEv && bitCnt_r[3:0] == 4'hF && !modeChg |=> !pcmOe_r)
    else $error("pcm output held past last bit");
  chk_pcm_unused: assert property (isPcm && riseEv && !txOwn[2] && !modeChg |=> !audioSerialDataOe)
    else $error("pcm output driven on unowned slot");
  chk_short_sync: assert property (isPcm && isMaster && !ctrl_r.longSync && $rose(frameOut_r)
    |-> bitCnt_r == pcmLast)
    else $error("short sync not in last bit");
  chk_long_sync: assert property (isPcm && isMaster && ctrl_r.longSync && $rose(frameOut_r)
    |-> bitCnt_r == 8'h00)
    else $error("long sync does not start with first bit");
  chk_div_tick: assert property (tick |=> !tick)
    else $error("divider ticked on consecutive cycles");

  cov_i2s_word: cover property (isI2s && fallEv && wsChg);
  cov_pcm_slot: cover property (isPcm && riseEv && txOwn[2] && nextBit_r[3:0] == 4'h0);
  cov_slave_sync: cover property (isPcm && !isMaster && fallEv && frameLvl);

endmodule : audio_serial_port

`default_nettype wire

// ### testbench/audio_codec_model.sv
// audio_codec_model: far-end i2s device; captures our words on rising
// bit-clock edges and, while run is high, acts as the i2s clock master.
// assumes the bench resolves every pin from the design's output enables.
`timescale 1ns/1ps
`default_nettype none

module audio_codec_model #(
  parameter int          HALF_NS = 163,
  parameter logic [15:0] LEFT_W  = 16'h3C5A,
  parameter logic [15:0] RIGHT_W = 16'hB1E6
) (
  // pins as resolved on the board
  input  wire logic        clkPin,
  input  wire logic        framePin,
  input  wire logic        dataPin,
  input  wire logic        run,
  // far-end drives
  output logic             clkDrv,
  output logic             frameDrv,
  output logic             dataDrv,
  // captured words
  output logic      [15:0] rxLeft,
  output logic      [15:0] rxRight,
  output logic      [7:0]  frameBits
);
  logic [15:0] sr;
  logic        wsPrev;
  logic        wsLat;
  int          n;
  int          cnt;
  int          i;
  int          j;

  initial begin
    clkDrv = 1'b0;
    frameDrv = 1'b0;
    dataDrv = 1'b0;
    wsPrev = 1'b0;
    wsLat = 1'b0;
    n = 0;
    cnt = 0;
  end

  // 326 ns period keeps under the slave clock ceiling
  always begin
    if (run !== 1'b1) @(posedge run);
    for (i = 0; i < 32; i++) begin
      #HALF_NS;
      clkDrv = 1'b0;
      frameDrv = i >= 16;
      j = (i + 31) % 32;
      dataDrv = j < 16 ? LEFT_W[15 - j] : RIGHT_W[31 - j];
      #HALF_NS;
      clkDrv = 1'b1;
    end
  end

  // idle data line never shows a steady stale level
  always @(negedge clkPin) if (run !== 1'b1) dataDrv = ~dataDrv;

  // lsb of a word shares its bit with the next ws change
  always @(posedge clkPin) begin
    if (n >= 1 && n <= 16) begin
      sr = {sr[14:0], dataPin};
      if (n == 16 && wsLat) rxRight = sr;
      if (n == 16 && !wsLat) rxLeft = sr;
      n++;
    end
    if (framePin !== wsPrev) begin
      n = 1;
      wsLat = framePin;
      if (framePin === 1'b0) begin
        frameBits = 8'(cnt);
        cnt = 0;
      end
    end
    cnt++;
    wsPrev = framePin;
  end
endmodule : audio_codec_model
`default_nettype wire

// ### testbench/audio_serial_port_bench.sv
// audio_serial_port_bench: programs the port over ahb-lite and judges the
// serial pins; assumes zero-wait slave and a 100 MHz mclk.
`timescale 1ns/1ps
`default_nettype none

module audio_serial_port_bench
  import audio_port_pkg::*;
;
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        clkOut, clkOe, frmOut, frmOe, datOut, datOe;
  logic        clkDrv, frameDrv, dataDrv, lastD, run;
  logic [15:0] rxL, rxR;
  logic [7:0]  fBits;
  wire         clkPin = clkOe ? clkOut : clkDrv;
  wire         framePin = frmOe ? frmOut : frameDrv;
  wire         dataPin = datOe ? datOut : ~lastD;
  int          checks = 0;
  int          failCount = 0;

  audio_serial_port dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .audioSerialClkIn(clkPin), .audioSerialClkOut(clkOut), .audioSerialClkOe(clkOe),
    .audioSerialFrameIn(framePin), .audioSerialFrameOut(frmOut),
    .audioSerialFrameOe(frmOe), .audioSerialDataOut(datOut), .audioSerialDataOe(datOe),
    .audio_serial_data_in_unused_guard(1'b0), .audioSerialDataIn(dataDrv)
  );

  audio_codec_model codec (
    .clkPin(clkPin), .framePin(framePin), .dataPin(dataPin), .run(run),
    .clkDrv(clkDrv), .frameDrv(frameDrv), .dataDrv(dataDrv),
    .rxLeft(rxL), .rxRight(rxR), .frameBits(fBits)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial lastD = 1'b0;
  always @(posedge mclk) if (datOe) lastD <= datOut;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus

  // counts mclk until the frame pin falls
  task automatic waitFall(output int c);
    logic p;
    p = framePin;
    for (c = 0; c < 6000; c++) begin
      @(negedge mclk);
      if (p === 1'b1 && framePin === 1'b0) break;
      p = framePin;
    end
    if (c == 6000) chk("frame edge", 1, 0);
  endtask : waitFall

  task automatic reg_test();
    bus(0, CTRL_OFS, 0);
    chk("ctrl reset", 0, rdat);
    bus(0, DIV_OFS, 0);
    chk("div reset", DIV_RST, rdat);
    bus(1, 8'h3C, 32'hFFFF_FFFF);
    bus(0, 8'h3C, 0);
    chk("unmapped", 0, rdat);
    bus(1, SLOT_OFS, 32'h0000_7FFF);
    bus(0, SLOT_OFS, 0);
    chk("slot readback", 32'h0000_7FFF, rdat);
    chk("oe idle", 0, {hresp, clkOe, frmOe, datOe});
    $display("register test done");
  endtask : reg_test

  task automatic i2s_master(input logic [31:0] ctl, dv, input logic [15:0] l, r,
                            input logic [7:0] bits);
    int c;
    bus(1, DIV_OFS, dv);
    bus(1, TX0_OFS, {16'h0, l});
    bus(1, TX1_OFS, {16'h0, r});
    bus(1, CTRL_OFS, ctl);
    repeat (3) waitFall(c);
    chk("frame mclk", 1, c > 3121 && c < 3127);
    chk("frame bits", bits, fBits);
    chk("left word", l, rxL);
    chk("right word", r, rxR);
    chk("oe master", 3'b111, {clkOe, frmOe, datOe});
    $display("i2s master test done");
  endtask : i2s_master

  task automatic i2s_slave();
    int c;
    bus(1, TX0_OFS, 32'h0000_9C31);
    bus(1, CTRL_OFS, 32'h2);
    run <= 1'b1;
    repeat (3) waitFall(c);
    chk("oe slave", 3'b001, {clkOe, frmOe, datOe});
    chk("slave left out", 16'h9C31, rxL);
    bus(0, RX0_OFS, 0);
    chk("rx left", 16'h3C5A, rdat[15:0]);
    bus(0, RX1_OFS, 0);
    chk("rx right", 16'hB1E6, rdat[15:0]);
    run <= 1'b0;
    $display("i2s slave test done");
  endtask : i2s_slave

  // ch0 owns slot 1 of a two-slot frame
  task automatic pcm_master(input logic [31:0] ctl, fmt, input logic [12:0] tx,
                            input logic [2:0] fill);
    int k;
    logic [15:0] w;
    w = {tx, fill};
    bus(1, FMT_OFS, fmt);
    bus(1, SLOT_OFS, 32'h11);
    bus(1, TX0_OFS, {19'h0, tx});
    bus(1, CTRL_OFS, ctl);
    @(negedge mclk);
    chk("pcm clk oe", 2'b11, {clkOe, frmOe});
    for (k = 0; k < 40 && framePin !== 1'b0; k++) @(negedge clkPin);
    for (k = 0; k < 40 && framePin !== 1'b1; k++) @(negedge clkPin);
    chk("sync seen", 1, framePin);
    for (k = 32'(ctl[7]); k < 32; k++) begin
      @(negedge clkPin);
      chk("sync level", ctl[7] ? k < 3 : k == 31, framePin);
      if (k < 31) chk("slot oe", k > 15, datOe);
      if (k > 15) chk("pcm bit", w[31 - k], datOut);
    end
    $display("pcm master test done");
  endtask : pcm_master

  task automatic off_test();
    bus(1, CTRL_OFS, 32'h5);
    @(negedge mclk);
    chk("oe reserved", 0, {clkOe, frmOe, datOe});
    bus(1, CTRL_OFS, 32'h4);
    repeat (300) @(negedge mclk);
    chk("oe pcm slave", 0, {clkOe, frmOe, datOe});
    bus(0, STAT_OFS, 0);
    chk("stat pcm slave", 32'h0000_0200, rdat);
    $display("off and pcm slave test done");
  endtask : off_test

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    #950_000;
    failCount++;
    print_verdict();
  end

  initial begin
    {rst, hsel, htrans, hwrite, haddr, hwdata, run} = {1'b1, 69'h0};
    hsize = 3'h2;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    reg_test();
    i2s_master(32'h01, 32'h0C35_0040, 16'hA5C3, 16'h5E17, 8'd32);
    i2s_master(32'h09, 32'h007D_0004, 16'h81F0, 16'h7E0F, 8'd50);
    i2s_slave();
    pcm_master(32'h13, 32'h00, 13'h1ABC, 3'b000);
    pcm_master(32'h93, 32'h04, 13'h0ABC, 3'b111);
    pcm_master(32'h13, 32'h08, 13'h1ABC, 3'b111);
    pcm_master(32'h93, 32'h5C, 13'h0ABC, 3'b101);
    off_test();
    print_verdict();
  end
endmodule : audio_serial_port_bench
`default_nettype wire
